// ==== src/fcsu_pkg.sv ====
// constants for the frame check sequence unit
package fcsu_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h04;
  localparam logic [7:0] STAT_IDX = 8'h06;
  localparam logic [7:0] MODE_IDX = 8'h08;
  localparam logic [7:0] INFO_IDX = 8'h09;
  // register fields and reset values
  localparam int AUTOCRC_BIT = 5;
  localparam int CRCVAL_BIT = 7;
  localparam int AACK_BIT = 0;
  localparam int ARET_BIT = 1;
  localparam logic [7:0] CTRL_RST = 8'h22;
  // checksum generator x^16+x^12+x^5+1, bit reversed for lsb-first shifting
  localparam logic [15:0] CRC_POLY_REV = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  // frame lengths
  localparam logic [6:0] LEN_MIN_GEN = 7'h03;
  localparam logic [6:0] LEN_MAX = 7'h7f;
  localparam logic [6:0] LEN_MIN_CHK = 7'h02;
  localparam logic [6:0] ACK_LEN = 7'h05;
  // frame control field layout
  localparam logic [2:0] FT_DATA = 3'h1;
  localparam logic [2:0] FT_ACK = 3'h2;
  localparam logic [2:0] FT_CMD = 3'h3;
  localparam int SEC_BIT = 3;
  localparam int ARQ_BIT = 5;
  localparam int PANC_BIT = 6;
  localparam int DAM_LO = 10;
  localparam int FV_LO = 12;
  localparam int SAM_LO = 14;
  localparam logic [1:0] AM_NONE = 2'h0;
  localparam logic [1:0] AM_SHORT = 2'h2;
  // address field sizes in octets
  localparam logic [4:0] PAN_OCT = 5'h02;
  localparam logic [4:0] SHORT_OCT = 5'h02;
  localparam logic [4:0] EXT_OCT = 5'h08;
  // transmit sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PASS = 5'b00010,
    ST_ACK = 5'b00100,
    ST_FCS0 = 5'b01000,
    ST_FCS1 = 5'b10000
  } fcsu_tx_t;
endpackage

// ==== src/fcsu_top.sv ====
// frame check sequence unit with apb registers, transmit and receive paths
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
module fcsu_top
  import fcsu_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic rstn, // synchronous reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic txStart, // start frame from buffer
  input wire logic [6:0] txLen, // frame length N
  output logic txBusy, // sequencer busy
  input wire logic [7:0] txByte, // buffer octet
  input wire logic txValid, // buffer octet valid
  output logic txReady, // buffer octet taken
  output logic [7:0] txOutByte, // link octet, bit 0 first
  output logic txOutLast, // last octet of frame
  output logic txOutValid, // link octet valid
  input wire logic txOutReady, // link takes octet
  output logic [6:0] txOutLen, // length of frame on link
  input wire logic rxStart, // received frame begins
  input wire logic [6:0] rxLen, // received length N
  input wire logic [7:0] rxByte, // received octet
  input wire logic rxValid, // received octet valid
  output logic frameEnd, // frame end event
  output logic ackAccept, // acknowledgement accepted
  output logic ackReject // acknowledgement refused
);

  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
    $error("fcsu_top: ADDR_W out of range");
  end

  // one octet through the lsb-first checksum shifter
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ CRC_POLY_REV;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // octets taken by one address field
  function automatic logic [4:0] addr_oct(input logic [1:0] m);
    if (m == AM_SHORT) begin
      return SHORT_OCT;
    end else if (m == 2'h3) begin
      return EXT_OCT;
    end
    return 5'h00;
  endfunction

  // header summary: [4:0] address octets, 5 ok, 6 and 8 security header, 7 and 9 format
  function automatic logic [9:0] hdr_info(input logic [15:0] f);
    logic [1:0] dm;
    logic [1:0] sm;
    logic [4:0] n;
    logic ok;
    dm = f[DAM_LO+:2];
    sm = f[SAM_LO+:2];
    n = 5'h00;
    if (dm != AM_NONE) begin
      n = PAN_OCT + addr_oct(dm);
    end
    if (sm != AM_NONE) begin
      n = n + addr_oct(sm);
      if (!(dm != AM_NONE && f[PANC_BIT])) begin
        n = n + PAN_OCT;
      end
    end
    ok = (dm != AM_NONE) || (sm != AM_NONE) || (f[2:0] == FT_ACK);
    return {f[FV_LO+1], f[SEC_BIT], f[FV_LO], f[SEC_BIT], ok, n};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and apb slave

  logic [7:0] ctrl_r;
  logic [1:0] mode_r;
  logic crcValid_r;
  logic [9:0] info_r;
  logic [31:0] prdata_r;
  logic [ADDR_W-3:0] regIdx;
  logic regHit;
  logic wrEn;
  logic [31:0] rdVal;

  // register index decode, byte address is index times four
  always_comb begin
    regIdx = paddr[ADDR_W-1:2];
    regHit = (paddr[1:0] == 2'h0) &&
             ((regIdx == (ADDR_W-2)'(CTRL_IDX)) || (regIdx == (ADDR_W-2)'(STAT_IDX)) ||
              (regIdx == (ADDR_W-2)'(MODE_IDX)) || (regIdx == (ADDR_W-2)'(INFO_IDX)));
    rdVal = 32'h00000000;
    case (regIdx)
      (ADDR_W-2)'(CTRL_IDX): rdVal = {24'h000000, ctrl_r};
      (ADDR_W-2)'(STAT_IDX): rdVal = {24'h000000, crcValid_r, 7'h00};
      (ADDR_W-2)'(MODE_IDX): rdVal = {30'h0, mode_r};
      (ADDR_W-2)'(INFO_IDX): rdVal = {22'h0, info_r};
      default: rdVal = 32'h00000000;
    endcase
    // misaligned or unmapped places read as zero
    if (!regHit) begin
      rdVal = 32'h00000000;
    end
  end

  assign wrEn = psel && penable && pwrite && regHit;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !regHit;
  assign prdata = prdata_r;

  // read data captured in the setup cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_r <= rdVal;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST;
      mode_r <= 2'h0;
    end else if (wrEn && regIdx == (ADDR_W-2)'(CTRL_IDX)) begin
      ctrl_r <= pwdata[7:0];
    end else if (wrEn && regIdx == (ADDR_W-2)'(MODE_IDX)) begin
      mode_r <= pwdata[1:0];
    end
  end

  logic autoCrc;
  logic autoAck;
  logic autoRet;
  assign autoCrc = ctrl_r[AUTOCRC_BIT];
  assign autoAck = mode_r[AACK_BIT];
  assign autoRet = mode_r[ARET_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // receive checker

  logic rxAct_r;
  logic [6:0] rxLen_r;
  logic [6:0] rxCnt_r;
  logic [15:0] rxCrc_r;
  logic [15:0] rxFcf_r;
  logic [7:0] rxSeq_r;
  logic [15:0] rxCrcNxt;
  logic [15:0] fcfNow;
  logic [7:0] seqNow;
  logic rxEnd;
  logic rxOk;
  logic isAck;

  always_comb begin
    rxCrcNxt = crc_byte(rxCrc_r, rxByte);
    rxEnd = rxAct_r && rxValid && (rxCnt_r + 7'h01 == rxLen_r);
    fcfNow = rxFcf_r;
    if (rxCnt_r == 7'h00) begin
      fcfNow[7:0] = rxByte;
    end else if (rxCnt_r == 7'h01) begin
      fcfNow[15:8] = rxByte;
    end
    seqNow = (rxCnt_r == 7'h02) ? rxByte : rxSeq_r;
    // residue zero over header, payload and checksum
    rxOk = (rxLen_r >= LEN_MIN_CHK) && (rxCrcNxt == 16'h0000);
    isAck = (fcfNow[2:0] == FT_ACK) && (rxLen_r == ACK_LEN);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rxAct_r <= 1'b0;
      rxLen_r <= 7'h00;
      rxCnt_r <= 7'h00;
      rxCrc_r <= CRC_INIT;
      rxFcf_r <= 16'h0000;
      rxSeq_r <= 8'h00;
    end else if (rxStart) begin
      rxAct_r <= (rxLen != 7'h00);
      rxLen_r <= rxLen;
      rxCnt_r <= 7'h00;
      rxCrc_r <= CRC_INIT;
    end else if (rxAct_r && rxValid) begin
      rxCrc_r <= rxCrcNxt;
      rxCnt_r <= rxCnt_r + 7'h01;
      rxFcf_r <= fcfNow;
      rxSeq_r <= seqNow;
      if (rxEnd) begin
        rxAct_r <= 1'b0;
      end
    end
  end

  logic [7:0] txSeq_r;
  logic retAck;
  assign retAck = autoRet && isAck;

  // frame end suppressed for bad frames in auto-acknowledge
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      frameEnd <= 1'b0;
      ackAccept <= 1'b0;
      ackReject <= 1'b0;
    end else begin
      frameEnd <= rxEnd && !retAck && !(autoAck && !rxOk);
      ackAccept <= rxEnd && retAck && rxOk && (seqNow == txSeq_r);
      ackReject <= rxEnd && retAck && !(rxOk && (seqNow == txSeq_r));
    end
  end

  // flag and header summary change only with frame end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      crcValid_r <= 1'b0;
      info_r <= 10'h000;
    end else if (rxEnd && !retAck && !(autoAck && !rxOk)) begin
      crcValid_r <= rxOk;
      info_r <= hdr_info(fcfNow);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit sequencer

  fcsu_tx_t txSt_r;
  logic [6:0] txCnt_r;
  logic [6:0] txLen_r;
  logic txGen_r;
  logic [15:0] txCrc_r;
  logic ackPend_r;
  logic [7:0] ackSeq_r;
  logic outValid_r;
  logic [7:0] outByte_r;
  logic outLast_r;
  logic [6:0] outLen_r;
  logic adv;
  logic load;
  logic [7:0] byteNxt;
  logic lastNxt;
  logic ackReq;
  logic ackTake;

  assign adv = !outValid_r || txOutReady;
  assign txReady = (txSt_r == ST_PASS) && adv;
  assign txBusy = (txSt_r != ST_IDLE);
  assign txOutByte = outByte_r;
  assign txOutLast = outLast_r;
  assign txOutValid = outValid_r;
  assign txOutLen = outLen_r;
  assign ackTake = (txSt_r == ST_IDLE) && ackPend_r;
  assign ackReq = rxEnd && autoAck && rxOk && fcfNow[ARQ_BIT] &&
                  (fcfNow[2:0] == FT_DATA || fcfNow[2:0] == FT_CMD);

  // next link octet
  always_comb begin
    load = 1'b0;
    byteNxt = 8'h00;
    lastNxt = 1'b0;
    case (txSt_r)
      ST_PASS: begin
        load = txValid && adv;
        byteNxt = txByte;
        lastNxt = !txGen_r && (txCnt_r + 7'h01 == txLen_r);
      end
      ST_ACK: begin
        load = adv;
        byteNxt = (txCnt_r == 7'h00) ? {5'h00, FT_ACK} :
                  (txCnt_r == 7'h01) ? 8'h00 : ackSeq_r;
      end
      // low remainder byte first, r0 in bit 0
      ST_FCS0: begin
        load = adv;
        byteNxt = txCrc_r[7:0];
      end
      ST_FCS1: begin
        load = adv;
        byteNxt = txCrc_r[15:8];
        lastNxt = 1'b1;
      end
      default: begin
        load = 1'b0;
      end
    endcase
  end

  // pending acknowledgement, a new request wins over the take
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ackPend_r <= 1'b0;
      ackSeq_r <= 8'h00;
    end else if (ackReq) begin
      ackPend_r <= 1'b1;
      ackSeq_r <= seqNow;
    end else if (ackTake) begin
      ackPend_r <= 1'b0;
    end
  end

  // sequencer state, count and checksum
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      txSt_r <= ST_IDLE;
      txCnt_r <= 7'h00;
      txLen_r <= 7'h00;
      txGen_r <= 1'b0;
      txCrc_r <= CRC_INIT;
      txSeq_r <= 8'h00;
      outLen_r <= 7'h00;
    end else begin
      case (txSt_r)
        ST_IDLE: begin
          txCnt_r <= 7'h00;
          txCrc_r <= CRC_INIT;
          if (ackPend_r) begin
            txSt_r <= ST_ACK;
            txGen_r <= 1'b1;
            txLen_r <= ACK_LEN;
            outLen_r <= ACK_LEN;
          end else if (txStart && txLen != 7'h00) begin
            txSt_r <= ST_PASS;
            txGen_r <= autoCrc && txLen >= LEN_MIN_GEN && txLen <= LEN_MAX;
            txLen_r <= txLen;
            outLen_r <= txLen;
          end
        end
        ST_PASS: begin
          if (load) begin
            txCrc_r <= crc_byte(txCrc_r, txByte);
            txCnt_r <= txCnt_r + 7'h01;
            if (txCnt_r == 7'h02) begin
              txSeq_r <= txByte;
            end
            // only N-2 octets drawn when generating
            if (txGen_r && txCnt_r + 7'h03 == txLen_r) begin
              txSt_r <= ST_FCS0;
            end else if (lastNxt) begin
              txSt_r <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (load) begin
            txCrc_r <= crc_byte(txCrc_r, byteNxt);
            txCnt_r <= txCnt_r + 7'h01;
            if (txCnt_r == 7'h02) begin
              txSt_r <= ST_FCS0;
            end
          end
        end
        ST_FCS0: begin
          if (load) begin
            txSt_r <= ST_FCS1;
          end
        end
        ST_FCS1: begin
          if (load) begin
            txSt_r <= ST_IDLE;
          end
        end
        default: txSt_r <= ST_IDLE;
      endcase
    end
  end

  // link output holding register
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      outValid_r <= 1'b0;
      outByte_r <= 8'h00;
      outLast_r <= 1'b0;
    end else if (load) begin
      outValid_r <= 1'b1;
      outByte_r <= byteNxt;
      outLast_r <= lastNxt;
    end else if (txOutReady) begin
      outValid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_ctrl_reset: assert property (
    @(posedge mclk) !rstn |=> ctrl_r[AUTOCRC_BIT] && !crcValid_r)
    else $error("generation bit not one after reset");

  chk_fcs_low_byte: assert property (
    @(posedge mclk) disable iff (!rstn)
    txSt_r == ST_FCS0 && adv |=> outByte_r == $past(txCrc_r[7:0]) && txSt_r == ST_FCS1)
    else $error("low checksum octet wrong");

  chk_gen_replace: assert property (
    @(posedge mclk) disable iff (!rstn)
    txSt_r == ST_PASS && txGen_r && load && txCnt_r + 7'h03 == txLen_r
    |=> txSt_r == ST_FCS0 && !outLast_r)
    else $error("checksum not placed at N-2");

  chk_ack_fcs: assert property (
    @(posedge mclk) disable iff (!rstn)
    txSt_r == ST_ACK && load && txCnt_r == 7'h02 |=> txSt_r == ST_FCS0)
    else $error("reply without checksum");

  chk_ack_seq: assert property (
    @(posedge mclk) disable iff (!rstn)
    txSt_r == ST_ACK && load && txCnt_r == 7'h02 |=> outByte_r == $past(ackSeq_r))
    else $error("reply sequence not echoed");

  chk_flag_hold: assert property (
    @(posedge mclk) disable iff (!rstn)
    $changed(crcValid_r) |-> frameEnd)
    else $error("valid flag changed without frame end");

  chk_aack_drop: assert property (
    @(posedge mclk) disable iff (!rstn)
    rxEnd && autoAck && !rxOk |=> !frameEnd && $stable(crcValid_r))
    else $error("bad frame raised frame end");

  chk_aret_refuse: assert property (
    @(posedge mclk) disable iff (!rstn)
    rxEnd && retAck && (!rxOk || seqNow != txSeq_r) |=> ackReject && !ackAccept)
    else $error("bad acknowledgement accepted");

  chk_rx_clear: assert property (
    @(posedge mclk) disable iff (!rstn)
    rxStart |=> rxCrc_r == CRC_INIT && rxCnt_r == 7'h00)
    else $error("checksum not cleared at frame start");

  chk_short_frame: assert property (
    @(posedge mclk) disable iff (!rstn)
    rxEnd && rxLen_r < LEN_MIN_CHK && !autoAck && !retAck |=> frameEnd && !crcValid_r)
    else $error("short frame reported valid");

endmodule

// ==== bench/fcsu_link_node.sv ====
// link-side node model that takes transmitted octets, with optional stalls
`timescale 1ns/100ps
module fcsu_link_node (
  input wire logic mclk, // system clock
  input wire logic rstn, // synchronous reset
  input wire logic slow, // stall the link at random
  input wire logic [7:0] txOutByte, // octet from the device
  input wire logic txOutLast, // last octet flag
  input wire logic txOutValid, // octet valid
  output logic txOutReady = 1'h0 // octet taken
);
  logic [8:0] octs[$]; // captured octets, last flag on top

  ////////////////////////////////////////////////////////////////////////////////
  // capture at ready edges; ready does not wait for valid, and with slow set it may drop at any edge
  always @(posedge mclk) begin
    if (txOutValid === 1'h1 && txOutReady === 1'h1) begin
      octs.push_back({txOutLast, txOutByte});
    end
    txOutReady <= !rstn ? 1'h0 : (slow ? 1'($urandom % 2) : 1'h1);
  end
endmodule

// ==== bench/test_frame_check_sequence_unit.sv ====
// self-checking bench for the frame check sequence unit
`timescale 1ns/100ps
module test_frame_check_sequence_unit;
  import fcsu_pkg::*;
  localparam logic [11:0] A_CTRL = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, STAT_IDX, 2'h0};
  localparam logic [11:0] A_MODE = {2'h0, MODE_IDX, 2'h0};
  localparam logic [11:0] A_INFO = {2'h0, INFO_IDX, 2'h0};
  logic mclk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, txStart = 1'h0, txBusy, txValid = 1'h0, txReady;
  logic txOutLast, txOutValid, txOutReady, rxStart = 1'h0, rxValid = 1'h0, slow = 1'h0;
  logic frameEnd, ackAccept, ackReject;
  logic [6:0] txLen = 7'h00, rxLen = 7'h00, txOutLen;
  logic [7:0] txByte = 8'h00, txOutByte, rxByte = 8'h00, seq;
  logic [15:0] c;
  int fail_count = 0, check_count = 0, nEnd = 0, nAcc = 0, nRej = 0, e0, a0, r0;
  int lens[4] = '{3, 5, 6, 127};
  logic [15:0] fcfs[5] = '{16'h0002, 16'h0001, 16'hcc09, 16'h9841, 16'h2801};
  byte unsigned q[$], exp[$];

  always #2 mclk = ~mclk;

  fcsu_top u_dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .txStart(txStart), .txLen(txLen), .txBusy(txBusy), .txByte(txByte), .txValid(txValid),
    .txReady(txReady), .txOutByte(txOutByte), .txOutLast(txOutLast), .txOutValid(txOutValid),
    .txOutReady(txOutReady), .txOutLen(txOutLen), .rxStart(rxStart), .rxLen(rxLen),
    .rxByte(rxByte), .rxValid(rxValid), .frameEnd(frameEnd), .ackAccept(ackAccept),
    .ackReject(ackReject));

  fcsu_link_node u_node (.mclk(mclk), .rstn(rstn), .slow(slow), .txOutByte(txOutByte),
    .txOutLast(txOutLast), .txOutValid(txOutValid), .txOutReady(txOutReady));

  // count event pulses seen at each edge
  always @(posedge mclk) begin
    nEnd <= nEnd + int'(frameEnd === 1'h1);
    nAcc <= nAcc + int'(ackAccept === 1'h1);
    nRej <= nRej + int'(ackReject === 1'h1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic give_up();
    fail_count++;
    results();
  endtask

  // reference checksum: lsb-first shifting, zero start
  function automatic logic [15:0] crc16(input byte unsigned d[$]);
    logic [15:0] r;
    logic fb;
    r = 16'h0000;
    foreach (d[i]) begin
      for (int b = 0; b < 8; b++) begin
        fb = r[0] ^ d[i][b];
        r = r >> 1;
        if (fb) r = r ^ 16'h8408;
      end
    end
    return r;
  endfunction

  // expected frame information word from the control field
  function automatic logic [31:0] info_of(input logic [15:0] f);
    logic [4:0] n;
    logic dp, sp;
    dp = f[11:10] != 2'h0;
    sp = f[15:14] != 2'h0;
    n = dp ? ((f[11] & f[10]) ? 5'h0a : 5'h04) : 5'h00;
    n = n + (sp ? ((f[15] & f[14]) ? 5'h08 : 5'h02) + ((dp & f[6]) ? 5'h00 : 5'h02) : 5'h00);
    return {22'h0, f[13], f[3], f[12], f[3], (dp | sp | (f[2:0] == 3'h2)), n};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) give_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // start a frame of length n and supply the given buffer octets
  task automatic tx_frame(input byte unsigned d[$], input int n);
    int k;
    u_node.octs.delete();
    @(posedge mclk);
    txStart <= 1'h1;
    txLen <= 7'(n);
    @(posedge mclk);
    txStart <= 1'h0;
    foreach (d[i]) begin
      txValid <= 1'h1;
      txByte <= d[i];
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (txReady !== 1'h1 && k < 50);
      if (k >= 50) give_up();
    end
    txValid <= 1'h0;
    txByte <= ~txByte;
  endtask

  // wait for the link octets and compare bytes and last flag
  task automatic expect_link(input byte unsigned e[$]);
    int k;
    k = 0;
    while (u_node.octs.size() < e.size() && k < 1000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 1000) give_up();
    repeat (3) @(posedge mclk);
    check(u_node.octs.size(), e.size());
    foreach (e[i]) check(u_node.octs[i], {i == e.size() - 1, e[i]});
    check(txOutLen, e.size());
    check(txBusy, 1'h0);
  endtask

  // receive octets; event pulse counts since start land in e0, a0, r0
  task automatic rx_frame(input byte unsigned d[$]);
    @(posedge mclk);
    e0 = nEnd;
    a0 = nAcc;
    r0 = nRej;
    rxStart <= 1'h1;
    rxLen <= 7'(d.size());
    foreach (d[i]) begin
      @(posedge mclk);
      rxStart <= 1'h0;
      rxValid <= 1'h1;
      rxByte <= d[i];
    end
    @(posedge mclk);
    rxValid <= 1'h0;
    rxByte <= ~rxByte;
    repeat (4) @(posedge mclk);
    e0 = nEnd - e0;
    a0 = nAcc - a0;
    r0 = nRej - r0;
  endtask

  function automatic void add_crc(inout byte unsigned d[$], input logic bad);
    logic [15:0] r;
    r = crc16(d) ^ {15'h0, bad};
    d.push_back(r[7:0]);
    d.push_back(r[15:8]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0107));
    repeat (5) @(posedge mclk);
    rstn <= 1'h1;
    // register reset values, read-only status, unmapped and misaligned places
    apb(1'h1, A_CTRL + 12'h002, 32'h0);
    apb(1'h0, A_CTRL + 12'h002, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'h0, A_CTRL, 32'h0);
    check(rd, 32'h22);
    apb(1'h1, A_STAT, 32'hff);
    apb(1'h0, A_STAT, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 12'h040, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    q = {8'h02, 8'h00, 8'h6a};
    check(crc16(q), 16'h79e4);
    // generated checksum over n-2 octets, each frame from zero
    lens[2] = 6 + $urandom % 20;
    foreach (lens[j]) begin
      slow <= 1'(j);
      q = {};
      repeat (lens[j] - 2) q.push_back(8'($urandom));
      exp = q;
      add_crc(exp, 1'h0);
      tx_frame(q, lens[j]);
      expect_link(exp);
    end
    // length two passes unchanged even with generation on
    q = {8'($urandom), 8'($urandom)};
    tx_frame(q, 2);
    expect_link(q);
    // generation off: all n octets pass
    pwdata <= 32'h0;
    apb(1'h1, A_CTRL, $urandom & 32'hffffffdf);
    c = pwdata[15:0];
    apb(1'h0, A_CTRL, 32'h0);
    check(rd, {24'h0, c[7:0]});
    q = {};
    repeat (7) q.push_back(8'($urandom));
    tx_frame(q, 7);
    expect_link(q);
    // receive checks: good, corrupted, too short
    for (int m = 0; m < 3; m++) begin
      q = {};
      repeat (m == 2 ? 1 : 6) q.push_back(8'($urandom));
      if (m < 2) add_crc(q, 1'(m));
      rx_frame(q);
      check(e0, 1);
      repeat (2) begin
        apb(1'h0, A_STAT, 32'h0);
        check(rd, m == 0 ? 32'h80 : 32'h0);
      end
    end
    // frame information from the control field
    foreach (fcfs[j]) begin
      q = {fcfs[j][7:0], fcfs[j][15:8], 8'($urandom)};
      add_crc(q, 1'h0);
      rx_frame(q);
      apb(1'h0, A_INFO, 32'h0);
      check(rd, info_of(fcfs[j]));
    end
    // auto-acknowledge with generation off
    apb(1'h1, A_MODE, 32'h1);
    apb(1'h1, A_CTRL, 32'h0);
    seq = 8'($urandom);
    q = {8'h21, 8'h08, seq, 8'hcd, 8'hab, 8'h34, 8'h12};
    add_crc(q, 1'h1);
    rx_frame(q);
    check(e0, 0);
    apb(1'h0, A_STAT, 32'h0);
    check(rd, 32'h80);
    q = {8'h21, 8'h08, seq, 8'hcd, 8'hab, 8'h34, 8'h12};
    add_crc(q, 1'h0);
    u_node.octs.delete();
    rx_frame(q);
    check(e0, 1);
    exp = {8'h02, 8'h00, seq};
    add_crc(exp, 1'h0);
    expect_link(exp);
    // auto-retry: acknowledgement checks on checksum and sequence
    apb(1'h1, A_CTRL, 32'h22);
    apb(1'h1, A_MODE, 32'h2);
    q = {8'h21, 8'h08, seq, 8'hcd, 8'hab};
    exp = q;
    add_crc(exp, 1'h0);
    tx_frame(q, 7);
    expect_link(exp);
    for (int m = 0; m < 3; m++) begin
      q = {8'h02, 8'h00, seq ^ {7'h0, m == 1}};
      add_crc(q, m == 2);
      rx_frame(q);
      check({e0[3:0], a0[3:0], r0[3:0]}, m == 0 ? 12'h010 : 12'h001);
    end
    results();
  end
endmodule
